/* src/sfcp_pkg.sv */
// shared constants and types for the serial flash command and protect block
package sfcp_pkg;

	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
	localparam logic [7:0] OP_RD_STATUS_LO = 8'h05;
	localparam logic [7:0] OP_RD_STATUS_HI = 8'h35;
	localparam logic [7:0] OP_WR_STATUS = 8'h01;
	localparam logic [7:0] OP_WR_STATUS_HI = 8'h31;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0b;
	localparam logic [7:0] OP_DUAL_READ = 8'h3b;
	localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_HALF_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] OP_PROGRAM = 8'h02;
	localparam logic [7:0] OP_SEC_ERASE = 8'h44;
	localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
	localparam logic [7:0] OP_SEC_READ = 8'h48;
	localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
	localparam logic [7:0] OP_RELEASE = 8'hab;
	localparam logic [7:0] OP_ID_READ = 8'h90;
	localparam logic [7:0] OP_IDENT = 8'h9f;
	localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;

	// ------------------------------------------------------------
	// byte counts, including the opcode byte, and the index of the last bit of a byte
	// ------------------------------------------------------------
	localparam logic [2:0] HDR_NONE = 3'h1;
	localparam logic [2:0] HDR_ADDR = 3'h4;
	localparam logic [2:0] HDR_DUMMY = 3'h5;
	localparam logic [2:0] STATUS_ONE = 3'h2;
	localparam logic [2:0] STATUS_TWO = 3'h3;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// ------------------------------------------------------------
	// protected region tops, index is the protect range code, then security register address fields
	// ------------------------------------------------------------
	localparam logic [7:1][23:0] PROT_LIMIT = {24'h07ffff, 24'h03ffff, 24'h05ffff,
		24'h06ffff, 24'h077fff, 24'h07bfff, 24'h07dfff};
	localparam logic [7:0] SEC_TOP = 8'h00;
	localparam logic [3:0] SEC_REG_ONE = 4'h1;
	localparam logic [3:0] SEC_REG_TWO = 4'h2;
	localparam logic [3:0] SEC_MID = 4'h0;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {AOP_NONE = 4'h0, AOP_PROG_LOAD = 4'h1, AOP_PROG_COMMIT = 4'h2,
		AOP_PROG_ABORT = 4'h3, AOP_ERASE_PAGE = 4'h4, AOP_ERASE_SECTOR = 4'h5,
		AOP_ERASE_HALF = 4'h6, AOP_ERASE_BLOCK = 4'h7, AOP_ERASE_CHIP = 4'h8,
		AOP_SEC_ERASE = 4'h9, AOP_STATUS_WRITE = 4'ha} sfcp_aop_type;
	typedef struct packed {
		logic valid;
		logic sec;
		sfcp_aop_type op;
		logic [23:0] addr;
		logic [7:0] data;
	} sfcp_req_type;
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic lane0;
		logic wp_n;
	} sfcp_pins_type;
	typedef enum logic [4:0] {ST_IDLE = 5'h01, ST_OPCODE = 5'h02, ST_BODY = 5'h04,
		ST_OUT = 5'h08, ST_IGNORE = 5'h10} sfcp_state_type;

endpackage : sfcp_pkg

/* src/sfcp_core.sv */
// command decode, write gating and protection of the serial flash
`timescale 1ns/1ps

module sfcp_core #(
	parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] PART_CODE = 8'h21, // arbitrary value
	parameter logic [7:0] IDENT_HIGH = 8'h44, // arbitrary value
	parameter logic [7:0] IDENT_LOW = 8'h31 // arbitrary value
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// serial pins
	input wire logic chip_select_n,
	input wire logic serial_clock,
	input wire logic dual_lane_zero_in,
	input wire logic dual_lane_one_in,
	input wire logic write_protect_n,
	output logic dual_lane_zero_out,
	output logic dual_lane_zero_oe_n,
	output logic dual_lane_one_out,
	output logic dual_lane_one_oe_n,
	// array engine
	input wire logic busy_flag,
	input wire logic [7:0] array_rd_data,
	output logic [23:0] array_rd_addr,
	output sfcp_pkg::sfcp_req_type array_req,
	// status view
	output logic write_latch,
	output logic [2:0] protect_range,
	output logic status_lock_bit,
	output logic [1:0] otp_lock,
	output logic deep_power_down
);

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] hdr_len(input logic [7:0] code);
		case (code)
			sfcp_pkg::OP_READ, sfcp_pkg::OP_ID_READ, sfcp_pkg::OP_RELEASE:
				hdr_len = sfcp_pkg::HDR_ADDR;
			sfcp_pkg::OP_FAST_READ, sfcp_pkg::OP_DUAL_READ, sfcp_pkg::OP_SEC_READ:
				hdr_len = sfcp_pkg::HDR_DUMMY;
			default:
				hdr_len = sfcp_pkg::HDR_NONE;
		endcase
	endfunction : hdr_len

	function automatic logic is_read(input logic [7:0] code);
		case (code)
			sfcp_pkg::OP_RD_STATUS_LO, sfcp_pkg::OP_RD_STATUS_HI, sfcp_pkg::OP_READ,
			sfcp_pkg::OP_FAST_READ, sfcp_pkg::OP_DUAL_READ, sfcp_pkg::OP_SEC_READ,
			sfcp_pkg::OP_ID_READ, sfcp_pkg::OP_RELEASE, sfcp_pkg::OP_IDENT:
				is_read = 1'b1;
			default:
				is_read = 1'b0;
		endcase
	endfunction : is_read

	function automatic logic is_known(input logic [7:0] code);
		case (code)
			sfcp_pkg::OP_WRITE_UNLOCK, sfcp_pkg::OP_WRITE_LOCK, sfcp_pkg::OP_WR_STATUS,
			sfcp_pkg::OP_WR_STATUS_HI, sfcp_pkg::OP_PAGE_ERASE, sfcp_pkg::OP_SECTOR_ERASE,
			sfcp_pkg::OP_HALF_ERASE, sfcp_pkg::OP_BLOCK_ERASE, sfcp_pkg::OP_CHIP_ERASE_A,
			sfcp_pkg::OP_CHIP_ERASE_B, sfcp_pkg::OP_PROGRAM, sfcp_pkg::OP_SEC_ERASE,
			sfcp_pkg::OP_SEC_PROGRAM, sfcp_pkg::OP_POWER_DOWN, sfcp_pkg::OP_RESET_ENABLE,
			sfcp_pkg::OP_RESET:
				is_known = 1'b1;
			default:
				is_known = is_read(code);
		endcase
	endfunction : is_known

	function automatic logic prot_hit(input logic [23:0] a, input logic [2:0] range);
		prot_hit = (range != 3'h0) && (a <= sfcp_pkg::PROT_LIMIT[range]);
	endfunction : prot_hit

	// ------------------------------------------------------------
	// pin synchronisers and edge detect
	// ------------------------------------------------------------
	sfcp_pkg::sfcp_pins_type pin_meta;
	sfcp_pkg::sfcp_pins_type pin_sync;
	logic sclk_prev;
	logic cs_prev;
	wire sfcp_pkg::sfcp_pins_type pin_raw = {chip_select_n, serial_clock, dual_lane_zero_in,
		write_protect_n};

	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			pin_meta <= 4'h9;
			pin_sync <= 4'h9;
			sclk_prev <= 1'b0;
			cs_prev <= 1'b1;
		end
		else
		begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			sclk_prev <= pin_sync.sclk;
			cs_prev <= pin_sync.cs_n;
		end

	wire sclk_rise = pin_sync.sclk & ~sclk_prev;
	wire sclk_fall = ~pin_sync.sclk & sclk_prev;
	wire cs_fall = ~pin_sync.cs_n & cs_prev;
	wire cs_rise = pin_sync.cs_n & ~cs_prev;
	wire wp_high = pin_sync.wp_n;

	// ------------------------------------------------------------
	// input shifting and counting
	// ------------------------------------------------------------
	sfcp_pkg::sfcp_state_type state;
	sfcp_pkg::sfcp_state_type next_state;
	logic [2:0] bit_cnt;
	logic [2:0] byte_cnt;
	logic [7:0] shift_in;
	logic [7:0] op;
	logic [23:0] addr;
	logic [7:0] status_lo_in;
	logic [7:0] status_hi_in;
	logic [7:0] prog_off;
	logic reset_armed;

	wire receiving = (state == sfcp_pkg::ST_OPCODE) | (state == sfcp_pkg::ST_BODY);
	wire [7:0] in_byte = {shift_in[6:0], pin_sync.lane0};
	wire byte_done = sclk_rise & receiving & (bit_cnt == sfcp_pkg::LAST_BIT);
	wire [2:0] next_byte_cnt = (byte_cnt == 3'h7) ? byte_cnt : byte_cnt + 3'h1;
	wire addr_byte = (byte_cnt >= sfcp_pkg::HDR_NONE) & (byte_cnt < sfcp_pkg::HDR_ADDR);
	wire [23:0] next_addr = (byte_done & addr_byte) ? {addr[15:0], in_byte} : addr;
	wire aligned = (bit_cnt == 3'h0) & (byte_cnt != 3'h0);
	wire opcode_ok = is_known(in_byte) & (~deep_power_down | (in_byte == sfcp_pkg::OP_RELEASE));

	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			bit_cnt <= 3'h0;
			byte_cnt <= 3'h0;
			shift_in <= 8'h00;
		end
		else if (cs_fall)
		begin
			bit_cnt <= 3'h0;
			byte_cnt <= 3'h0;
		end
		else if (sclk_rise & receiving)
		begin
			bit_cnt <= bit_cnt + 3'h1;
			shift_in <= in_byte;
			if (byte_done)
				byte_cnt <= next_byte_cnt;
		end

	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			op <= 8'h00;
			addr <= 24'h000000;
			status_lo_in <= 8'h00;
			status_hi_in <= 8'h00;
		end
		else if (byte_done)
		begin
			if (state == sfcp_pkg::ST_OPCODE)
				op <= in_byte;
			addr <= next_addr;
			if (byte_cnt == sfcp_pkg::HDR_NONE)
				status_lo_in <= in_byte;
			if (byte_cnt == sfcp_pkg::STATUS_ONE)
				status_hi_in <= in_byte;
		end

	// ------------------------------------------------------------
	// command state machine
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		unique case (state)
			sfcp_pkg::ST_IDLE:
				if (cs_fall)
					next_state = sfcp_pkg::ST_OPCODE;
			sfcp_pkg::ST_OPCODE:
				if (byte_done)
				begin
					if (!opcode_ok)
						next_state = sfcp_pkg::ST_IGNORE;
					else if (is_read(in_byte) && hdr_len(in_byte) == sfcp_pkg::HDR_NONE)
						next_state = sfcp_pkg::ST_OUT;
					else
						next_state = sfcp_pkg::ST_BODY;
				end
			sfcp_pkg::ST_BODY:
				if (byte_done && is_read(op) && next_byte_cnt == hdr_len(op))
					next_state = sfcp_pkg::ST_OUT;
			sfcp_pkg::ST_OUT, sfcp_pkg::ST_IGNORE:
				next_state = state;
			default:
				next_state = sfcp_pkg::ST_IDLE;
		endcase
		if (cs_rise)
			next_state = sfcp_pkg::ST_IDLE;
	end

	always_ff @(posedge clk or posedge reset)
		if (reset)
			state <= sfcp_pkg::ST_IDLE;
		else
			state <= next_state;

	// ------------------------------------------------------------
	// write decisions at deselect, program loads at each received data byte
	// ------------------------------------------------------------
	wire in_body = state == sfcp_pkg::ST_BODY;
	wire exec = cs_rise & in_body & aligned;
	wire is_prog = (op == sfcp_pkg::OP_PROGRAM) | (op == sfcp_pkg::OP_SEC_PROGRAM);
	wire is_sec = (op == sfcp_pkg::OP_SEC_PROGRAM) | (op == sfcp_pkg::OP_SEC_ERASE);
	wire sec_reg1 = addr[15:12] == sfcp_pkg::SEC_REG_ONE;
	wire sec_reg2 = addr[15:12] == sfcp_pkg::SEC_REG_TWO;
	wire sec_ok = (addr[23:16] == sfcp_pkg::SEC_TOP) & (addr[11:8] == sfcp_pkg::SEC_MID) &
		((sec_reg1 & ~otp_lock[0]) | (sec_reg2 & ~otp_lock[1]));
	wire write_ok = write_latch & ~busy_flag;
	wire area_ok = is_sec ? sec_ok : ~prot_hit(addr, protect_range);
	wire prog_ok = write_ok & area_ok;
	wire is_erase = (op == sfcp_pkg::OP_PAGE_ERASE) | (op == sfcp_pkg::OP_SECTOR_ERASE) |
		(op == sfcp_pkg::OP_HALF_ERASE) | (op == sfcp_pkg::OP_BLOCK_ERASE) |
		(op == sfcp_pkg::OP_SEC_ERASE);
	wire is_chip = (op == sfcp_pkg::OP_CHIP_ERASE_A) | (op == sfcp_pkg::OP_CHIP_ERASE_B);
	wire do_erase = exec & is_erase & (byte_cnt == sfcp_pkg::HDR_ADDR) & prog_ok;
	wire do_chip = exec & is_chip & (byte_cnt == sfcp_pkg::HDR_NONE) & write_ok &
		(protect_range == 3'h0);
	wire has_data = byte_cnt >= sfcp_pkg::HDR_DUMMY;
	wire do_commit = exec & is_prog & has_data & prog_ok;
	wire do_abort = cs_rise & in_body & ~aligned & is_prog & has_data & prog_ok;
	wire do_load = byte_done & in_body & is_prog & (byte_cnt >= sfcp_pkg::HDR_ADDR) & prog_ok;
	wire sr_lo_valid = (op == sfcp_pkg::OP_WR_STATUS) &
		((byte_cnt == sfcp_pkg::STATUS_ONE) | (byte_cnt == sfcp_pkg::STATUS_TWO));
	wire sr_hi_valid = ((op == sfcp_pkg::OP_WR_STATUS) & (byte_cnt == sfcp_pkg::STATUS_TWO)) |
		((op == sfcp_pkg::OP_WR_STATUS_HI) & (byte_cnt == sfcp_pkg::STATUS_ONE));
	wire [7:0] sr_hi_byte = (op == sfcp_pkg::OP_WR_STATUS_HI) ? status_lo_in : status_hi_in;
	wire hw_locked = status_lock_bit & ~wp_high;
	wire do_status = exec & (sr_lo_valid | sr_hi_valid) & write_ok & ~hw_locked;
	wire do_unlock = exec & (op == sfcp_pkg::OP_WRITE_UNLOCK) & (byte_cnt == sfcp_pkg::HDR_NONE);
	wire do_lock = exec & (op == sfcp_pkg::OP_WRITE_LOCK) & (byte_cnt == sfcp_pkg::HDR_NONE);
	wire do_sleep = exec & (op == sfcp_pkg::OP_POWER_DOWN) & (byte_cnt == sfcp_pkg::HDR_NONE);
	wire do_wake = cs_rise & (in_body | (state == sfcp_pkg::ST_OUT)) &
		(op == sfcp_pkg::OP_RELEASE);
	wire do_arm = exec & (op == sfcp_pkg::OP_RESET_ENABLE) & (byte_cnt == sfcp_pkg::HDR_NONE);
	wire do_reset = exec & (op == sfcp_pkg::OP_RESET) & (byte_cnt == sfcp_pkg::HDR_NONE) &
		reset_armed;
	wire write_done = do_erase | do_chip | do_commit | do_status;
	wire [7:0] next_off = do_load ? prog_off + 8'h01 : prog_off;

	sfcp_pkg::sfcp_req_type next_req;
	always_comb
	begin
		next_req = '0;
		next_req.sec = is_sec;
		next_req.addr = addr;
		next_req.data = in_byte;
		if (do_status)
		begin
			next_req.op = sfcp_pkg::AOP_STATUS_WRITE;
			next_req.addr = {8'h00, sr_hi_byte, status_lo_in};
		end
		else if (do_chip)
			next_req.op = sfcp_pkg::AOP_ERASE_CHIP;
		else if (do_commit)
			next_req.op = sfcp_pkg::AOP_PROG_COMMIT;
		else if (do_abort)
			next_req.op = sfcp_pkg::AOP_PROG_ABORT;
		else if (do_load)
		begin
			next_req.op = sfcp_pkg::AOP_PROG_LOAD;
			next_req.addr = {addr[23:8], addr[7:0] + prog_off};
		end
		else if (do_erase)
		begin
			unique case (op)
				sfcp_pkg::OP_PAGE_ERASE: next_req.op = sfcp_pkg::AOP_ERASE_PAGE;
				sfcp_pkg::OP_SECTOR_ERASE: next_req.op = sfcp_pkg::AOP_ERASE_SECTOR;
				sfcp_pkg::OP_HALF_ERASE: next_req.op = sfcp_pkg::AOP_ERASE_HALF;
				sfcp_pkg::OP_BLOCK_ERASE: next_req.op = sfcp_pkg::AOP_ERASE_BLOCK;
				default: next_req.op = sfcp_pkg::AOP_SEC_ERASE;
			endcase
		end
		next_req.valid = next_req.op != sfcp_pkg::AOP_NONE;
	end

	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			array_req <= '0;
			prog_off <= 8'h00;
		end
		else
		begin
			array_req <= next_req;
			prog_off <= cs_fall ? 8'h00 : next_off;
		end

	// ------------------------------------------------------------
	// latch, status bits and power state
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			write_latch <= 1'b0;
			deep_power_down <= 1'b0;
			reset_armed <= 1'b0;
		end
		else
		begin
			if (do_unlock)
				write_latch <= 1'b1;
			else if (do_lock | write_done | do_reset)
				write_latch <= 1'b0;
			if (do_sleep)
				deep_power_down <= 1'b1;
			else if (do_wake | do_reset)
				deep_power_down <= 1'b0;
			if (cs_rise & (state != sfcp_pkg::ST_IDLE))
				reset_armed <= do_arm;
		end

	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			protect_range <= 3'h0;
			status_lock_bit <= 1'b0;
			otp_lock <= 2'h0;
		end
		else if (do_status)
		begin
			if (sr_lo_valid & wp_high)
			begin
				protect_range <= status_lo_in[4:2];
				status_lock_bit <= status_lo_in[7];
			end
			if (sr_hi_valid)
				otp_lock <= otp_lock | sr_hi_byte[4:3];
		end

	// ------------------------------------------------------------
	// output shifting
	// ------------------------------------------------------------
	logic [7:0] out_shift;
	logic [2:0] out_pos;
	logic [1:0] out_idx;
	wire dual = op == sfcp_pkg::OP_DUAL_READ;
	wire [7:0] status_lo = {status_lock_bit, 2'b00, protect_range, write_latch, busy_flag};
	wire [7:0] status_hi = {3'b000, otp_lock, 3'b000};
	wire [7:0] id90_byte = out_idx[0] ? PART_CODE : MAKER_CODE;
	wire [7:0] ident_byte = (out_idx == 2'h0) ? MAKER_CODE :
		(out_idx == 2'h1) ? IDENT_HIGH : IDENT_LOW;
	wire [7:0] src_byte = (op == sfcp_pkg::OP_RD_STATUS_LO) ? status_lo :
		(op == sfcp_pkg::OP_RD_STATUS_HI) ? status_hi :
		(op == sfcp_pkg::OP_ID_READ) ? id90_byte :
		(op == sfcp_pkg::OP_RELEASE) ? PART_CODE :
		(op == sfcp_pkg::OP_IDENT) ? ident_byte : array_rd_data;
	wire load = out_pos == 3'h0;
	wire [7:0] cur_byte = load ? src_byte : out_shift;
	wire [2:0] hi_bit = 3'h7 - out_pos;
	wire [2:0] lo_bit = 3'h6 - out_pos;
	wire [2:0] step = dual ? 3'h2 : 3'h1;
	wire [1:0] next_idx = ((op == sfcp_pkg::OP_IDENT) && out_idx == 2'h2) ? 2'h0 : out_idx + 2'h1;
	wire out_fall = sclk_fall & (state == sfcp_pkg::ST_OUT);
	wire enter_out = (next_state == sfcp_pkg::ST_OUT) & (state != sfcp_pkg::ST_OUT);

	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			out_shift <= 8'h00;
			out_pos <= 3'h0;
			out_idx <= 2'h0;
			array_rd_addr <= 24'h000000;
		end
		else if (enter_out)
		begin
			out_pos <= 3'h0;
			out_idx <= 2'h0;
			array_rd_addr <= next_addr;
		end
		else if (out_fall)
		begin
			out_pos <= out_pos + step;
			if (load)
			begin
				out_shift <= src_byte;
				out_idx <= next_idx;
				array_rd_addr <= array_rd_addr + 24'h000001;
			end
		end

	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			dual_lane_one_out <= 1'b0;
			dual_lane_zero_out <= 1'b0;
			dual_lane_one_oe_n <= 1'b1;
			dual_lane_zero_oe_n <= 1'b1;
		end
		else
		begin
			dual_lane_one_oe_n <= state != sfcp_pkg::ST_OUT;
			dual_lane_zero_oe_n <= !((state == sfcp_pkg::ST_OUT) && dual);
			if (out_fall)
			begin
				dual_lane_one_out <= cur_byte[hi_bit];
				dual_lane_zero_out <= cur_byte[lo_bit];
			end
		end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	a_latch_from_unlock: assert property ($rose(write_latch) |->
		$past(op) == sfcp_pkg::OP_WRITE_UNLOCK && $past(cs_rise)) else $error("latch rose badly");
	a_erase_needs_latch: assert property (array_req.valid && array_req.op !=
		sfcp_pkg::AOP_PROG_LOAD |-> $past(write_latch)) else $error("write without latch");
	a_commit_aligned: assert property (array_req.valid &&
		array_req.op == sfcp_pkg::AOP_PROG_COMMIT |-> $past(bit_cnt) == 3'h0)
		else $error("commit off byte boundary");
	a_abort_keeps_latch: assert property (array_req.valid &&
		array_req.op == sfcp_pkg::AOP_PROG_ABORT |-> write_latch) else $error("abort lost latch");
	a_erase_outside_range: assert property (array_req.valid &&
		array_req.op == sfcp_pkg::AOP_ERASE_SECTOR |-> !prot_hit(array_req.addr, $past(protect_range)))
		else $error("erase inside protected range");
	a_pin_freezes_range: assert property (!wp_high && $past(!wp_high) |->
		$stable(protect_range) && $stable(status_lock_bit)) else $error("range changed with pin low");
	a_sleep_ignores: assert property (deep_power_down && state == sfcp_pkg::ST_BODY |->
		op == sfcp_pkg::OP_RELEASE) else $error("command taken in power-down");
	a_output_off_idle: assert property (!dual_lane_one_oe_n || !dual_lane_zero_oe_n |->
		is_read(op) && (dual_lane_zero_oe_n || dual)) else $error("output driven outside read");

endmodule : sfcp_core

/* testbench/sfcp_host.sv */
// host side serial controller model for the flash command block
`timescale 1ns/1ps
module sfcp_host (
	// clock
	input wire logic clk,
	// serial pins
	output logic cs_n,
	output logic sclk,
	output logic mosi,
	input wire logic miso,
	input wire logic miso0,
	input wire logic miso_oe_n
);
	logic [63:0] rx;
	logic [63:0] rx0;
	logic oe_seen;
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	// half of the 80 ns link period
	task automatic half;
		repeat (8) @(negedge clk);
	endtask : half
	// one framed mode 0 transfer of nbits
	task automatic frame(input logic [63:0] tx, input int nbits);
		rx = 64'h0;
		rx0 = 64'h0;
		oe_seen = 1'b0;
		@(negedge clk);
		cs_n = 1'b0;
		for (int i = nbits - 1; i >= 0; i--)
		begin
			mosi = tx[i];
			half();
			sclk = 1'b1;
			rx = {rx[62:0], miso};
			rx0 = {rx0[62:0], miso0};
			oe_seen = oe_seen | ~miso_oe_n;
			half();
			sclk = 1'b0;
		end
		half();
		cs_n = 1'b1;
		mosi = ~mosi;
		repeat (16) @(negedge clk);
	endtask : frame
endmodule : sfcp_host

/* testbench/tb.sv */
// self-checking bench for the flash command and protect block
`timescale 1ns/1ps
module tb;
	logic clk, reset, cs_n, sclk, mosi, wp_n, z_out, z_oe_n, o_out, o_oe_n;
	logic lat, lock, dpd, busy;
	logic [2:0] rng;
	logic [1:0] otp;
	logic [23:0] rd_addr;
	sfcp_pkg::sfcp_req_type req;
	sfcp_pkg::sfcp_req_type reqs[$];
	int miscompares = 0;
	int total_checks = 0;
	logic [7:0] ops[4] = '{8'h81, 8'h20, 8'h52, 8'hd8};
	logic [3:0] aops[4] = '{4'h4, 4'h5, 4'h6, 4'h7};
	// ------------------------------------------------------------
	// clock, model and device
	// ------------------------------------------------------------
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	always @(posedge clk) if (req.valid === 1'b1) reqs.push_back(req);
	sfcp_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
		.miso(o_out), .miso0(z_out), .miso_oe_n(o_oe_n));
	sfcp_core u_dut (.clk(clk), .reset(reset), .chip_select_n(cs_n), .serial_clock(sclk),
		.dual_lane_zero_in(z_oe_n ? mosi : z_out), .dual_lane_one_in(o_oe_n ? 1'b1 : o_out),
		.write_protect_n(wp_n), .dual_lane_zero_out(z_out), .dual_lane_zero_oe_n(z_oe_n),
		.dual_lane_one_out(o_out), .dual_lane_one_oe_n(o_oe_n), .busy_flag(busy),
		.array_rd_data(rd_addr[7:0] ^ 8'h3c), .array_rd_addr(rd_addr), .array_req(req),
		.write_latch(lat), .protect_range(rng), .status_lock_bit(lock), .otp_lock(otp),
		.deep_power_down(dpd));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cmd(input logic [63:0] tx, input int nbits);
		u_host.frame(tx, nbits);
	endtask : cmd
	task automatic summarize;
		$display("checks %0d, miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	initial
	begin
		#400us;
		miscompares++;
		summarize();
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		wp_n = 1'b1;
		busy = 1'b0;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		chk({lat, dpd, rng}, 5'h00);
		cmd(64'h06, 8);
		chk(lat, 1'b1);
		cmd(64'h04, 8);
		chk(lat, 1'b0);
		cmd(64'h0c, 9);
		chk(lat, 1'b0);
		cmd(64'h02000100a5, 40);
		chk(reqs.size(), 0);
		$display("test latch done");
		cmd(64'h06, 8);
		cmd(64'h02000100a5, 40);
		chk({reqs[0].op, reqs[0].addr, reqs[0].data}, 36'h1000100a5);
		chk({reqs[1].op, lat}, 5'h4);
		cmd(64'h06, 8);
		cmd(64'h02000100a5a, 44);
		chk({reqs[$].op, lat}, 5'h7);
		cmd(64'h0104, 16);
		chk({reqs[$].op, reqs[$].addr[7:0], rng}, 15'h5021);
		cmd(64'h06, 8);
		cmd(64'h2007d000, 32);
		chk(reqs[$].op, sfcp_pkg::AOP_STATUS_WRITE);
		for (int i = 0; i < 4; i++)
		begin
			cmd(64'h06, 8);
			cmd({ops[i], 24'h07f000}, 32);
			chk(reqs[$].op, aops[i]);
		end
		wp_n = 1'b0;
		cmd(64'h06, 8);
		cmd(64'h0100, 16);
		chk(rng, 3'h1);
		wp_n = 1'b1;
		$display("test write gating done");
		cmd(64'h04, 8);
		u_host.frame(64'h050000, 24);
		chk(u_host.rx[15:0], 16'h0404);
		u_host.frame(64'h500000, 24);
		chk(u_host.oe_seen, 1'b0);
		cmd(64'hb9, 8);
		chk(dpd, 1'b1);
		cmd(64'h06, 8);
		chk(lat, 1'b0);
		cmd(64'hab, 8);
		chk(dpd, 1'b0);
		cmd(64'h06, 8);
		cmd(64'h66, 8);
		cmd(64'h99, 8);
		chk(lat, 1'b0);
		$display("test modes done");
		u_host.frame(64'h3b0000100000, 48);
		chk({u_host.rx[7:0], u_host.rx0[7:0]}, 16'h6623);
		chk(rd_addr, 24'h000013);
		u_host.frame(64'h0b000020000000, 56);
		chk(u_host.rx[15:0], 16'h1c1d);
		u_host.frame(64'h900000000000, 48);
		chk(u_host.rx[15:0], 16'h5a21);
		u_host.frame(64'hab00000000, 40);
		chk(u_host.rx[7:0], 8'h21);
		u_host.frame(64'h9f000000, 32);
		chk(u_host.rx[23:0], 24'h5a4431);
		$display("test reads done");
		cmd(64'h06, 8);
		cmd(64'h0180, 16);
		chk({lock, rng}, 4'h8);
		wp_n = 1'b0;
		cmd(64'h06, 8);
		cmd(64'h0104, 16);
		chk({lock, rng, lat}, 5'h11);
		wp_n = 1'b1;
		cmd(64'h0100, 16);
		chk({lock, lat}, 2'b00);
		cmd(64'h06, 8);
		cmd(64'hc7, 8);
		chk(reqs[$].op, 4'h8);
		cmd(64'h06, 8);
		cmd(64'h44003000, 32);
		chk(lat, 1'b1);
		cmd(64'h44001000, 32);
		chk({reqs[$].op, reqs[$].sec}, 5'h13);
		cmd(64'h06, 8);
		cmd(64'h3108, 16);
		chk(otp, 2'b01);
		cmd(64'h06, 8);
		cmd(64'h44001000, 32);
		chk(lat, 1'b1);
		u_host.frame(64'h350000, 24);
		chk(u_host.rx[15:0], 16'h0808);
		busy = 1'b1;
		cmd(64'h2007f000, 32);
		chk({reqs[$].op, lat}, 5'h15);
		busy = 1'b0;
		$display("test protect done");
		summarize();
	end
endmodule : tb
